// [design/evb_pkg.sv]
`default_nettype none
package evb_pkg;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int unsigned VEC_W       = 8;
  localparam int unsigned OFS_W       = 10;
  localparam int unsigned SW_W        = 16;
  localparam int unsigned ADDR_W      = 32;
  localparam int unsigned PEND_W      = 3;

  // vector numbers of the exception table
  localparam logic [7:0] VEC_RESET_SP   = 8'h00;
  localparam logic [7:0] VEC_RESET_PC   = 8'h01;
  localparam logic [7:0] VEC_BUS_ERR    = 8'h02;
  localparam logic [7:0] VEC_ADDR_ERR   = 8'h03;
  localparam logic [7:0] VEC_ILLEGAL    = 8'h04;
  localparam logic [7:0] VEC_ZERO_DIV   = 8'h05;
  localparam logic [7:0] VEC_CHK        = 8'h06;
  localparam logic [7:0] VEC_COND_TRAP  = 8'h07;
  localparam logic [7:0] VEC_PRIV       = 8'h08;
  localparam logic [7:0] VEC_TRACE      = 8'h09;
  localparam logic [7:0] VEC_LINE_A     = 8'h0a;
  localparam logic [7:0] VEC_LINE_F     = 8'h0b;
  localparam logic [7:0] VEC_PROTOCOL   = 8'h0d;
  localparam logic [7:0] VEC_FORMAT     = 8'h0e;
  localparam logic [7:0] VEC_UNINIT_INT = 8'h0f;
  localparam logic [7:0] VEC_SPURIOUS   = 8'h18;
  localparam logic [7:0] VEC_AUTO_BASE  = 8'h18;
  localparam logic [7:0] VEC_TRAP_BASE  = 8'h20;
  localparam logic [7:0] VEC_FLOAT_BASE = 8'h30;
  localparam logic [7:0] VEC_MMU_BASE   = 8'h38;
  localparam logic [7:0] VEC_USER_BASE  = 8'h40;

  localparam logic [7:0] AUTO_LVL_MAX   = 8'h07;
  localparam logic [7:0] FLOAT_IDX_MAX  = 8'h06;
  localparam logic [7:0] MMU_IDX_MAX    = 8'h02;

  // status word field positions
  localparam int unsigned SW_TRACE_HI_BIT = 15;
  localparam int unsigned SW_TRACE_LO_BIT = 14;
  localparam int unsigned SW_SUPER_BIT    = 13;

  localparam logic [SW_W-1:0]   SW_RESET   = 16'h0000;
  localparam logic [ADDR_W-1:0] WORD_RESET = 32'h0000_0000;
  localparam logic [PEND_W-1:0] PEND_ZERO  = 3'h0;
  localparam logic [PEND_W-1:0] PEND_ONE   = 3'h1;

  typedef enum logic [4:0] {
    CAUSE_RESET_SP, CAUSE_RESET_PC, CAUSE_BUS_ERR, CAUSE_ADDR_ERR, CAUSE_ILLEGAL,
    CAUSE_ZERO_DIV, CAUSE_CHK, CAUSE_COND_TRAP, CAUSE_PRIV, CAUSE_TRACE,
    CAUSE_LINE_A, CAUSE_LINE_F, CAUSE_PROTOCOL, CAUSE_FORMAT, CAUSE_UNINIT_INT,
    CAUSE_SPURIOUS, CAUSE_AUTOVEC, CAUSE_SW_TRAP, CAUSE_FLOAT, CAUSE_MMU,
    CAUSE_USER
  } evb_cause_t;

  typedef enum logic {SPACE_PROG, SPACE_DATA} evb_space_t;

  // table offset is four times the vector number
  function automatic logic [OFS_W-1:0] evb_offset(input logic [VEC_W-1:0] vec);
    evb_offset = {vec, 2'b00};
  endfunction

endpackage
`default_nettype wire

// [design/evb_vec_if.sv]
`default_nettype none
interface evb_vec_if;
  timeunit 1ns;
  timeprecision 1ps;
  import evb_pkg::*;
  evb_cause_t       cause;
  logic [7:0]       index;
  logic [7:0]       vector;
  logic [9:0]       offset;
  evb_space_t       space;
  logic             bad;

  modport mapper (input cause, input index, output vector, output offset, output space,
                  output bad);
  modport user   (output cause, output index, input vector, input offset, input space,
                  input bad);
endinterface
`default_nettype wire

// [design/evb_vec_map.sv]
`default_nettype none
module evb_vec_map (
  evb_vec_if.mapper vif
);
  timeunit 1ns;
  timeprecision 1ps;
  import evb_pkg::*;

  logic [7:0] vec;
  logic       bad;

  always_comb begin
    vec = VEC_ILLEGAL;
    bad = 1'b0;
    unique case (vif.cause)
      CAUSE_RESET_SP:   vec = VEC_RESET_SP;
      CAUSE_RESET_PC:   vec = VEC_RESET_PC;
      CAUSE_BUS_ERR:    vec = VEC_BUS_ERR;
      CAUSE_ADDR_ERR:   vec = VEC_ADDR_ERR;
      CAUSE_ILLEGAL:    vec = VEC_ILLEGAL;
      CAUSE_ZERO_DIV:   vec = VEC_ZERO_DIV;
      CAUSE_CHK:        vec = VEC_CHK;
      CAUSE_COND_TRAP:  vec = VEC_COND_TRAP;
      CAUSE_PRIV:       vec = VEC_PRIV;
      CAUSE_TRACE:      vec = VEC_TRACE;
      CAUSE_LINE_A:     vec = VEC_LINE_A;
      CAUSE_LINE_F:     vec = VEC_LINE_F;
      CAUSE_PROTOCOL:   vec = VEC_PROTOCOL;
      CAUSE_FORMAT:     vec = VEC_FORMAT;
      CAUSE_UNINIT_INT: vec = VEC_UNINIT_INT;
      CAUSE_SPURIOUS:   vec = VEC_SPURIOUS;
      CAUSE_AUTOVEC: begin
        vec = VEC_AUTO_BASE + vif.index;
        bad = (vif.index == 8'h00) || (vif.index > AUTO_LVL_MAX);
      end
      CAUSE_SW_TRAP: begin
        vec = VEC_TRAP_BASE + {4'h0, vif.index[3:0]};
        bad = (vif.index[7:4] != 4'h0);
      end
      CAUSE_FLOAT: begin
        vec = VEC_FLOAT_BASE + vif.index;
        bad = (vif.index > FLOAT_IDX_MAX);
      end
      CAUSE_MMU: begin
        vec = VEC_MMU_BASE + vif.index;
        bad = (vif.index > MMU_IDX_MAX);
      end
      CAUSE_USER: begin
        vec = vif.index;
        bad = (vif.index < VEC_USER_BASE);
      end
      default: begin
        vec = VEC_ILLEGAL;
        bad = 1'b1;
      end
    endcase
  end

  assign vif.vector = vec;
  assign vif.offset = evb_offset(vec);
  assign vif.space  = (vec == VEC_RESET_SP || vec == VEC_RESET_PC) ? SPACE_PROG : SPACE_DATA;
  assign vif.bad    = bad;

endmodule
`default_nettype wire

// [design/evb_exc_unit.sv]
`default_nettype none
module evb_exc_unit (
  input  wire logic                clock,
  input  wire logic                resetn,
  input  wire logic                exc_req,
  input  wire evb_pkg::evb_cause_t exc_cause,
  input  wire logic [7:0]          exc_index,
  output logic                     exc_ack,
  output logic                     vec_valid,
  output logic [7:0]               vec_num,
  output logic [9:0]               vec_offset,
  output evb_pkg::evb_space_t      vec_space,
  output logic                     vec_bad,
  input  wire logic                bus_cycle_start,
  input  wire logic                bus_cycle_end,
  input  wire logic                bus_fault_input,
  input  wire logic [31:0]         exec_pc,
  input  wire logic                sync_idle_instruction,
  input  wire logic [15:0]         status_word_in,
  output logic                     exec_stall,
  output logic                     status_word_load,
  output logic [15:0]              status_word_out,
  output logic                     push_valid,
  output logic [31:0]              push_data,
  input  wire logic                push_ack,
  output logic                     fetch_valid,
  output logic [9:0]               fetch_offset,
  output evb_pkg::evb_space_t      fetch_space,
  input  wire logic                fetch_ack,
  input  wire logic [31:0]         fetch_data,
  output logic                     init_done,
  output logic [31:0]              init_sp,
  output logic [31:0]              init_pc
);
  timeunit 1ns;
  timeprecision 1ps;

  import evb_pkg::*;

  typedef enum logic [3:0] {
    ST_FETCH_SP,
    ST_FETCH_PC,
    ST_IDLE,
    ST_BE_COPY,
    ST_BE_MODIFY,
    ST_PUSH_OFS,
    ST_PUSH_PC,
    ST_PUSH_SW
  } evb_state_t;

  typedef struct packed {
    evb_state_t      st;
    logic [2:0]      pend_cnt;
    logic            fault_pend;
    logic [31:0]     fault_pc;
    logic [31:0]     be_pc;
    logic            sync_active;
    logic [15:0]     sw_copy;
    logic [9:0]      be_offset;
    logic            exc_ack;
    logic            vec_valid;
    logic [7:0]      vec_num;
    logic [9:0]      vec_offset;
    evb_space_t      vec_space;
    logic            vec_bad;
    logic            exec_stall;
    logic            sw_load;
    logic [15:0]     sw_out;
    logic            push_valid;
    logic [31:0]     push_data;
    logic            fetch_valid;
    logic [9:0]      fetch_offset;
    evb_space_t      fetch_space;
    logic            init_done;
    logic [31:0]     init_sp;
    logic [31:0]     init_pc;
  } evb_regs_t;

  evb_regs_t s_ff;
  evb_regs_t nxt_s;

  evb_vec_if vif ();

  evb_vec_map u_map (
    .vif (vif.mapper)
  );

  logic            fault_seen;
  logic [2:0]      pend_next;
  evb_state_t      st_next;

  // mapper is steered by the current phase
  always_comb begin
    vif.cause = exc_cause;
    vif.index = exc_index;
    unique case (s_ff.st)
      ST_FETCH_SP: vif.cause = CAUSE_RESET_SP;
      ST_FETCH_PC: vif.cause = CAUSE_RESET_PC;
      ST_IDLE:     vif.cause = s_ff.fault_pend ? CAUSE_BUS_ERR : exc_cause;
      default:     vif.cause = CAUSE_BUS_ERR;
    endcase
  end

  always_comb begin
    nxt_s = s_ff;
    st_next = s_ff.st;
    nxt_s.exc_ack = 1'b0;
    nxt_s.vec_valid = 1'b0;
    nxt_s.sw_load = 1'b0;

    // fault latched only at cycle end
    fault_seen = bus_cycle_end && bus_fault_input && (s_ff.pend_cnt != PEND_ZERO);

    pend_next = s_ff.pend_cnt;
    // saturate rather than wrap past seven open cycles
    if (bus_cycle_start && !bus_cycle_end && s_ff.pend_cnt != ~PEND_ZERO) begin
      pend_next = s_ff.pend_cnt + PEND_ONE;
    end else if (!bus_cycle_start && bus_cycle_end && s_ff.pend_cnt != PEND_ZERO) begin
      pend_next = s_ff.pend_cnt - PEND_ONE;
    end
    nxt_s.pend_cnt = pend_next;

    // a pending fault keeps its PC unless it is being taken this cycle
    if (fault_seen && (!s_ff.fault_pend || s_ff.st == ST_IDLE)) begin
      // PC of instruction executing at detection
      nxt_s.fault_pc = exec_pc;
    end

    unique case (s_ff.st)
      ST_FETCH_SP: begin
        nxt_s.fetch_valid = 1'b1;
        nxt_s.fetch_offset = vif.offset;
        nxt_s.fetch_space = vif.space;
        if (s_ff.fetch_valid && fetch_ack) begin
          nxt_s.init_sp = fetch_data;
          nxt_s.fetch_valid = 1'b0;
          st_next = ST_FETCH_PC;
        end
      end
      ST_FETCH_PC: begin
        nxt_s.fetch_valid = 1'b1;
        nxt_s.fetch_offset = vif.offset;
        nxt_s.fetch_space = vif.space;
        if (s_ff.fetch_valid && fetch_ack) begin
          nxt_s.init_pc = fetch_data;
          nxt_s.fetch_valid = 1'b0;
          nxt_s.init_done = 1'b1;
          st_next = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (s_ff.fault_pend) begin
          // bus fault vector over other requests
          nxt_s.vec_valid = 1'b1;
          nxt_s.vec_num = vif.vector;
          nxt_s.vec_offset = vif.offset;
          nxt_s.vec_space = vif.space;
          nxt_s.vec_bad = 1'b0;
          nxt_s.be_offset = vif.offset;
          nxt_s.be_pc = s_ff.fault_pc;
          st_next = ST_BE_COPY;
        end else if (exc_req && s_ff.init_done) begin
          // a request still high at the ack edge is taken again
          // map a general cause to its vector
          nxt_s.exc_ack = 1'b1;
          nxt_s.vec_valid = 1'b1;
          nxt_s.vec_num = vif.vector;
          nxt_s.vec_offset = vif.offset;
          nxt_s.vec_space = vif.space;
          nxt_s.vec_bad = vif.bad;
        end
      end
      ST_BE_COPY: begin
        nxt_s.sw_copy = status_word_in;
        st_next = ST_BE_MODIFY;
      end
      ST_BE_MODIFY: begin
        nxt_s.sw_out = s_ff.sw_copy;
        nxt_s.sw_out[SW_SUPER_BIT] = 1'b1;
        nxt_s.sw_out[SW_TRACE_HI_BIT] = 1'b0;
        nxt_s.sw_out[SW_TRACE_LO_BIT] = 1'b0;
        nxt_s.sw_load = 1'b1;
        // first word is the vector offset
        nxt_s.push_valid = 1'b1;
        nxt_s.push_data = {22'h000000, s_ff.be_offset};
        st_next = ST_PUSH_OFS;
      end
      ST_PUSH_OFS: begin
        if (push_ack) begin
          nxt_s.push_data = s_ff.be_pc;
          st_next = ST_PUSH_PC;
        end
      end
      ST_PUSH_PC: begin
        if (push_ack) begin
          // then the saved status word copy
          nxt_s.push_data = {16'h0000, s_ff.sw_copy};
          st_next = ST_PUSH_SW;
        end
      end
      ST_PUSH_SW: begin
        if (push_ack) begin
          nxt_s.push_valid = 1'b0;
          nxt_s.push_data = WORD_RESET;
          st_next = ST_IDLE;
        end
      end
    endcase
    nxt_s.st = st_next;

    // a new fault wins over the clear of the one being taken
    nxt_s.fault_pend = ((s_ff.st == ST_IDLE) ? 1'b0 : s_ff.fault_pend) | fault_seen;
    if (s_ff.st == ST_IDLE && !s_ff.fault_pend) begin
      nxt_s.fault_pend = fault_seen;
    end

    // sync idle holds until the bus drains
    nxt_s.sync_active = (s_ff.sync_active || sync_idle_instruction) &&
                        (pend_next != PEND_ZERO);

    // stall spans the fault entry too
    nxt_s.exec_stall = nxt_s.sync_active || nxt_s.fault_pend ||
                       (st_next != ST_IDLE);
  end

  // exec_stall resets high so nothing runs before the reset fetch
  always_ff @(posedge clock) begin
    if (!resetn) begin
      s_ff <= '{
        st:           ST_FETCH_SP,
        pend_cnt:     PEND_ZERO,
        fault_pend:   1'b0,
        fault_pc:     WORD_RESET,
        be_pc:        WORD_RESET,
        sync_active:  1'b0,
        sw_copy:      SW_RESET,
        be_offset:    10'h000,
        exc_ack:      1'b0,
        vec_valid:    1'b0,
        vec_num:      8'h00,
        vec_offset:   10'h000,
        vec_space:    SPACE_PROG,
        vec_bad:      1'b0,
        exec_stall:   1'b1,
        sw_load:      1'b0,
        sw_out:       SW_RESET,
        push_valid:   1'b0,
        push_data:    WORD_RESET,
        fetch_valid:  1'b0,
        fetch_offset: 10'h000,
        fetch_space:  SPACE_PROG,
        init_done:    1'b0,
        init_sp:      WORD_RESET,
        init_pc:      WORD_RESET
      };
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign exc_ack          = s_ff.exc_ack;
  assign vec_valid        = s_ff.vec_valid;
  assign vec_num          = s_ff.vec_num;
  assign vec_offset       = s_ff.vec_offset;
  assign vec_space        = s_ff.vec_space;
  assign vec_bad          = s_ff.vec_bad;
  assign exec_stall       = s_ff.exec_stall;
  assign status_word_load = s_ff.sw_load;
  assign status_word_out  = s_ff.sw_out;
  assign push_valid       = s_ff.push_valid;
  assign push_data        = s_ff.push_data;
  assign fetch_valid      = s_ff.fetch_valid;
  assign fetch_offset     = s_ff.fetch_offset;
  assign fetch_space      = s_ff.fetch_space;
  assign init_done        = s_ff.init_done;
  assign init_sp          = s_ff.init_sp;
  assign init_pc          = s_ff.init_pc;

endmodule
`default_nettype wire

// [sim/evb_exc_unit_sva.sv]
`default_nettype none
module evb_exc_unit_sva (
  input wire logic                clock,
  input wire logic                resetn,
  input wire evb_pkg::evb_cause_t exc_cause,
  input wire logic [7:0]          exc_index,
  input wire logic                exc_ack,
  input wire logic                vec_valid,
  input wire logic [7:0]          vec_num,
  input wire logic [9:0]          vec_offset,
  input wire evb_pkg::evb_space_t vec_space,
  input wire logic                vec_bad,
  input wire logic                bus_cycle_end,
  input wire logic                bus_fault_input,
  input wire logic                exec_stall,
  input wire logic                status_word_load,
  input wire logic [15:0]         status_word_out,
  input wire logic                push_valid,
  input wire logic [31:0]         push_data,
  input wire logic                fetch_valid,
  input wire logic [9:0]          fetch_offset,
  input wire evb_pkg::evb_space_t fetch_space
);
  timeunit 1ns;
  timeprecision 1ps;
  import evb_pkg::*;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  sequence fault_end;
    bus_cycle_end && bus_fault_input;
  endsequence
  sequence err_vec;
    vec_valid && vec_num == VEC_BUS_ERR && vec_offset == 10'h008;
  endsequence
  a_offset_four: assert property (vec_valid |-> vec_offset == {vec_num, 2'b00})
    else $error("offset not four times vector");
  a_space_reset: assert property (vec_valid && !vec_bad |->
    (vec_space == SPACE_PROG) == (vec_num < 8'h02)) else $error("wrong vector space");
  a_autovec_map: assert property (exc_ack && $past(exc_cause) == CAUSE_AUTOVEC && !vec_bad
    |-> vec_num == VEC_AUTO_BASE + $past(exc_index)) else $error("autovector wrong");
  a_trap_map: assert property (exc_ack && $past(exc_cause) == CAUSE_SW_TRAP && !vec_bad
    |-> vec_num == VEC_TRAP_BASE + $past(exc_index)) else $error("trap vector wrong");
  a_fault_entry: assert property (fault_end |=> exec_stall ##1 err_vec)
    else $error("bus fault entry out of step");
  a_sw_bits: assert property (status_word_load |-> status_word_out[SW_SUPER_BIT] &&
    !status_word_out[SW_TRACE_HI_BIT] && !status_word_out[SW_TRACE_LO_BIT])
    else $error("status word not supervisor untraced");
  a_copy_first: assert property (status_word_load |-> $past(vec_valid, 2) &&
    push_valid && push_data == 32'h0000_0008) else $error("copy or push order wrong");
  a_stall_entry: assert property (push_valid |-> exec_stall)
    else $error("core ran during entry");
  a_reset_fetch: assert property (fetch_valid |-> fetch_space == SPACE_PROG &&
    (fetch_offset == 10'h000 || fetch_offset == 10'h004)) else $error("reset fetch wrong");
endmodule
bind evb_exc_unit evb_exc_unit_sva i_evb_exc_unit_sva (
  .clock(clock), .resetn(resetn), .exc_cause(exc_cause), .exc_index(exc_index),
  .exc_ack(exc_ack), .vec_valid(vec_valid), .vec_num(vec_num), .vec_offset(vec_offset),
  .vec_space(vec_space), .vec_bad(vec_bad), .bus_cycle_end(bus_cycle_end),
  .bus_fault_input(bus_fault_input), .exec_stall(exec_stall),
  .status_word_load(status_word_load), .status_word_out(status_word_out),
  .push_valid(push_valid), .push_data(push_data), .fetch_valid(fetch_valid),
  .fetch_offset(fetch_offset), .fetch_space(fetch_space)
);
`default_nettype wire

// [sim/evb_bus_slave.sv]
`default_nettype none
module evb_bus_slave #(
  parameter logic [31:0] SP_WORD = 32'h0000_2000,
  parameter logic [31:0] PC_WORD = 32'h0000_0400
) (
  input  wire logic       clock,
  input  wire logic       resetn,
  input  wire logic       cyc_go,
  input  wire logic       cyc_fault,
  input  wire logic       slow,
  input  wire logic       fetch_valid,
  input  wire logic [9:0] fetch_offset,
  input  wire logic       push_valid,
  output logic            bus_cycle_end,
  output logic            bus_fault_input,
  output logic            fetch_ack,
  output logic [31:0]     fetch_data,
  output logic            push_ack
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] cnt_ff;
  logic [1:0] wait_ff;
  logic       flt_ff;
  logic       ready;
  always_ff @(posedge clock) begin
    if (!resetn) begin
      cnt_ff <= 2'h0;
      wait_ff <= 2'h0;
      flt_ff <= 1'b0;
    end else begin
      if (cyc_go) begin
        cnt_ff <= slow ? 2'h3 : 2'h1;
        flt_ff <= cyc_fault;
      end else if (cnt_ff != 2'h0) begin
        cnt_ff <= cnt_ff - 2'h1;
      end
      wait_ff <= ((fetch_valid || push_valid) && !ready) ? wait_ff + 2'h1 : 2'h0;
    end
  end
  assign ready = wait_ff >= (slow ? 2'h2 : 2'h0);
  assign fetch_ack = fetch_valid && ready;
  assign push_ack = push_valid && ready;
  assign bus_cycle_end = cnt_ff == 2'h1;
  // a released fault line shows the inverse of its last level
  assign bus_fault_input = bus_cycle_end ? flt_ff : !flt_ff;
  assign fetch_data = !fetch_valid ? ~PC_WORD : (fetch_offset == 10'h000) ? SP_WORD :
                      (fetch_offset == 10'h004) ? PC_WORD : ~SP_WORD;
endmodule
`default_nettype wire

// [sim/test_evb_exc_unit.sv]
`default_nettype none
module test_evb_exc_unit;
  timeunit 1ns;
  timeprecision 1ps;
  import evb_pkg::*;
  localparam logic [31:0] SP_WORD = 32'h0000_2000;
  localparam logic [31:0] PC_WORD = 32'h0000_0400;
  logic        clock, resetn = 1'b0, exc_req = 1'b0, bus_go = 1'b0, cyc_fault = 1'b0;
  logic        slow = 1'b1, sync_idle_instruction = 1'b0;
  logic        exc_ack, vec_valid, vec_bad, bus_cycle_end, bus_fault_input, exec_stall;
  logic        status_word_load, push_valid, push_ack, fetch_valid, fetch_ack, init_done;
  evb_cause_t  exc_cause = CAUSE_RESET_SP;
  evb_space_t  vec_space, fetch_space;
  logic [7:0]  exc_index = 8'h00, vec_num;
  logic [9:0]  vec_offset, fetch_offset;
  logic [15:0] status_word_in = 16'hc71f, status_word_out;
  logic [31:0] exec_pc = 32'h0000_1100, push_data, fetch_data, init_sp, init_pc;
  int          num_errors = 0, comparisons = 0;

  evb_exc_unit i_evb_exc_unit (
    .clock(clock), .resetn(resetn), .exc_req(exc_req), .exc_cause(exc_cause),
    .exc_index(exc_index), .exc_ack(exc_ack), .vec_valid(vec_valid), .vec_num(vec_num),
    .vec_offset(vec_offset), .vec_space(vec_space), .vec_bad(vec_bad),
    .bus_cycle_start(bus_go), .bus_cycle_end(bus_cycle_end),
    .bus_fault_input(bus_fault_input), .exec_pc(exec_pc),
    .sync_idle_instruction(sync_idle_instruction), .status_word_in(status_word_in),
    .exec_stall(exec_stall), .status_word_load(status_word_load),
    .status_word_out(status_word_out), .push_valid(push_valid), .push_data(push_data),
    .push_ack(push_ack), .fetch_valid(fetch_valid), .fetch_offset(fetch_offset),
    .fetch_space(fetch_space), .fetch_ack(fetch_ack), .fetch_data(fetch_data),
    .init_done(init_done), .init_sp(init_sp), .init_pc(init_pc)
  );
  evb_bus_slave #(.SP_WORD(SP_WORD), .PC_WORD(PC_WORD)) i_evb_bus_slave (
    .clock(clock), .resetn(resetn), .cyc_go(bus_go), .cyc_fault(cyc_fault), .slow(slow),
    .fetch_valid(fetch_valid), .fetch_offset(fetch_offset), .push_valid(push_valid),
    .bus_cycle_end(bus_cycle_end), .bus_fault_input(bus_fault_input),
    .fetch_ack(fetch_ack), .fetch_data(fetch_data), .push_ack(push_ack)
  );

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic test_done();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic wait_hi(ref logic sig);
    for (int n = 0; n < 60 && sig !== 1'b1; n++) begin
      @(posedge clock);
    end
    if (sig !== 1'b1) begin
      check("timeout", 1'b0, 1'b1);
      test_done();
    end
  endtask

  task automatic map_one(input evb_cause_t c, input int i, input int v, input logic bad);
    @(posedge clock);
    exc_req <= 1'b1;
    exc_cause <= c;
    exc_index <= 8'(i);
    @(posedge clock);
    wait_hi(exc_ack);
    exc_req <= 1'b0;
    check("vec_bad", vec_bad, bad);
    if (!bad) begin
      check("vec_num", vec_num, 32'(v));
      check("vec_offset", vec_offset, 32'(v * 4));
      check("vec_space", vec_space, v > 1);
    end
    @(posedge clock);
  endtask

  task automatic map_range(input evb_cause_t c, input int lo, input int hi, input int base);
    for (int i = 0; i <= hi + 1; i++) begin
      map_one(c, i, base + i - lo, i < lo || i > hi);
    end
  endtask

  task automatic test_reset();
    repeat (10) @(posedge clock);
    resetn <= 1'b1;
    @(posedge clock);
    wait_hi(init_done);
    check("init_sp", init_sp, SP_WORD);
    check("init_pc", init_pc, PC_WORD);
  endtask

  task automatic test_mapping();
    // fixed causes skip the reserved vector 12 and end on the spurious one
    for (int i = 0; i < 16; i++) begin
      map_one(evb_cause_t'(i), 0, i < 12 ? i : i < 15 ? i + 1 : 24, 1'b0);
    end
    map_range(CAUSE_AUTOVEC, 1, 7, 25);
    map_range(CAUSE_SW_TRAP, 0, 15, 32);
    map_range(CAUSE_FLOAT, 0, 6, 48);
    map_range(CAUSE_MMU, 0, 2, 56);
    map_one(CAUSE_USER, 63, 63, 1'b1);
    map_one(CAUSE_USER, 255, 255, 1'b0);
  endtask

  task automatic test_bus(input logic fault, input logic sync);
    logic [31:0] exp [3];
    int got;
    exp = '{32'h0000_0008, 32'h0000_1104, 32'h0000_c71f};
    got = 0;
    @(posedge clock);
    bus_go <= 1'b1;
    cyc_fault <= fault;
    exec_pc <= 32'h0000_1100;
    status_word_in <= 16'hc71f;
    @(posedge clock);
    bus_go <= 1'b0;
    sync_idle_instruction <= sync;
    exec_pc <= 32'h0000_1104;
    @(posedge clock);
    sync_idle_instruction <= 1'b0;
    @(posedge clock);
    check("exec_stall", exec_stall, sync | (fault & !slow));
    if (!fault) begin
      repeat (2) @(posedge clock);
      check("exec_stall", exec_stall, 1'b0);
      check("vec_valid", vec_valid, 1'b0);
      return;
    end
    wait_hi(vec_valid);
    status_word_in <= 16'h0000;
    check("vec_num", vec_num, VEC_BUS_ERR);
    check("exec_stall", exec_stall, 1'b1);
    for (int n = 0; n < 40 && got < 3; n++) begin
      @(posedge clock);
      if (status_word_load) begin
        check("status_word_out", status_word_out, 16'h271f);
      end
      if (push_valid && push_ack) begin
        check("push_data", push_data, exp[got]);
        got++;
      end
    end
    check("pushes", got, 3);
    @(posedge clock);
    check("exec_stall", exec_stall, 1'b0);
  endtask

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  initial begin
    test_reset();
    test_mapping();
    test_bus(1'b0, 1'b1);
    test_bus(1'b1, 1'b0);
    test_bus(1'b1, 1'b1);
    slow <= 1'b0;
    test_bus(1'b1, 1'b0);
    test_bus(1'b0, 1'b0);
    test_done();
  end
endmodule
`default_nettype wire
